/* verilog/atx_pkg.sv */
// Package for the 48-bit task-file register block.
// Assumes a single 125 MHz clock domain and a plain register port.
package atx_pkg;
  // Task-file register offsets (command block and control).
  localparam logic [3:0] ATX_OFF_DATA = 4'h0;
  localparam logic [3:0] ATX_OFF_FEAT = 4'h1;
  localparam logic [3:0] ATX_OFF_SCNT = 4'h2;
  localparam logic [3:0] ATX_OFF_LBAL = 4'h3;
  localparam logic [3:0] ATX_OFF_LBAM = 4'h4;
  localparam logic [3:0] ATX_OFF_LBAH = 4'h5;
  localparam logic [3:0] ATX_OFF_DEV = 4'h6;
  localparam logic [3:0] ATX_OFF_CMD = 4'h7;
  localparam logic [3:0] ATX_OFF_DEVCTL = 4'hE;
  // Block-specific registers.
  localparam logic [3:0] ATX_OFF_STAT = 4'h8;
  localparam logic [3:0] ATX_OFF_ADDR0 = 4'h9;
  localparam logic [3:0] ATX_OFF_ADDR1 = 4'hA;
  localparam logic [3:0] ATX_OFF_ADDR2 = 4'hB;
  localparam logic [3:0] ATX_OFF_CNT = 4'hC;
  localparam logic [3:0] ATX_OFF_CNTH = 4'hD;
  localparam logic [3:0] ATX_OFF_IDW = 4'hF;
  // Field positions.
  localparam int ATX_HOB_BIT = 7;
  localparam int ATX_LBA_MODE_BIT = 6;
  localparam int ATX_ID83_48BIT = 10;
  // Reset values.
  localparam logic [7:0] ATX_DEVCTL_RST = 8'h00;
  localparam logic [7:0] ATX_BYTE_RST = 8'h00;
  // Address limits.
  localparam logic [47:0] ATX_MAX28 = 48'h0000_0FFF_FFFF;
  localparam logic [47:0] ATX_NATIVE_MAX_DEF = 48'h0000_0FFF_FFFF;
  // Identify word indexes.
  localparam logic [7:0] ATX_IDW_83 = 8'h53;
  localparam logic [7:0] ATX_IDW_100 = 8'h64;
  localparam logic [7:0] ATX_IDW_101 = 8'h65;
  localparam logic [7:0] ATX_IDW_102 = 8'h66;
  localparam logic [7:0] ATX_IDW_103 = 8'h67;
  // Command opcodes.
  localparam logic [7:0] ATX_C_FLUSH_X = 8'hEA;
  localparam logic [7:0] ATX_C_RDMA_X = 8'h25;
  localparam logic [7:0] ATX_C_RMUL_X = 8'h29;
  localparam logic [7:0] ATX_C_RNMAX_X = 8'h27;
  localparam logic [7:0] ATX_C_RSEC_X = 8'h24;
  localparam logic [7:0] ATX_C_RVER_X = 8'h42;
  localparam logic [7:0] ATX_C_SMAX_X = 8'h37;
  localparam logic [7:0] ATX_C_WDMA_X = 8'h35;
  localparam logic [7:0] ATX_C_WMUL_X = 8'h39;
  localparam logic [7:0] ATX_C_WSEC_X = 8'h34;
  localparam logic [7:0] ATX_C_RNMAX = 8'hF8;
  // Command decoder states.
  typedef enum logic [1:0] {
    ATX_IDLE = 2'b00,
    ATX_LATCH = 2'b01,
    ATX_DONE = 2'b10
  } atx_state_t;
endpackage

/* verilog/atx_bus_if.sv */
// Interface carrying one task-file write between the top and its FIFOs.
// Assumes all users share the top clock.
`timescale 1ns/10ps
interface atx_bus_if;
  // Write strobe for a single FIFO register.
  logic wr;
  // Byte being written.
  logic [7:0] wdata;
  // Newest and previous entries of the FIFO.
  logic [7:0] newest;
  logic [7:0] prev;
  modport ctl (output wr, output wdata, input newest, input prev);
  modport fifo (input wr, input wdata, output newest, output prev);
endinterface

/* verilog/atx_fifo2.sv */
// Two-entry byte FIFO used by each 48-bit task-file register.
// Assumes the write strobe is one clock wide and synchronous to mclk.
`timescale 1ns/10ps
module atx_fifo2
  import atx_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // Register side.
  atx_bus_if.fifo bus
);
  // Newest and previous bytes held in flops.
  logic [7:0] newest_r;
  logic [7:0] prev_r;

  // Each write shifts the newest byte into the previous slot.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      newest_r <= ATX_BYTE_RST;
      prev_r <= ATX_BYTE_RST;
    end else if (bus.wr) begin
      prev_r <= newest_r;
      newest_r <= bus.wdata;
    end
  end

  assign bus.newest = newest_r;
  assign bus.prev = prev_r;
endmodule

/* verilog/atx_taskfile.sv */
// Task-file register bank with 48-bit addressing support.
// Assumes a host register port in the mclk domain; reads answer next cycle.
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
// How it works
// - Five registers each hold two entries.
// - Select bit set reads previous entry.
// - Select bit clear reads newest entry.
// - Any command-block write clears select bit.
// - Writes always load the newest entry.
// - 48-bit commands use 16-bit sector count.
// - 48-bit commands use LBA addressing only.
// - 28-bit and 48-bit commands intermix freely.
// - Recognise the extended 48-bit command set.
// - Identify word 83 bit 10 flags 48-bit.
// - Identify words 100-103 hold max LBA.
// - Extended native-max read returns full value.
// - 28-bit native-max read clamps to 268435455.
// - Addresses are carried as 48-bit quantities.
module atx_taskfile
  import atx_pkg::*;
#(
  parameter logic [47:0] NATIVE_MAX = atx_pkg::ATX_NATIVE_MAX_DEF
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Decoded command outputs.
  output logic cmd_valid,
  output logic cmd_ext,
  output logic cmd_bad,
  output logic [7:0] cmd_code,
  output logic [47:0] cmd_lba,
  output logic [15:0] cmd_count,
  output logic [15:0] cmd_feat
);
  import atx_pkg::*;

  // Number of two-entry registers: features, count and three LBA bytes.
  localparam int NFIFO = 5;

  // Device control; bit 7 is the high-order-byte select.
  logic [7:0] devctl_r;
  // Device register; bit 6 picks LBA mode, bits 3:0 top 28-bit nibble.
  logic [7:0] dev_r;
  // Index of the identify word that the identify offsets read back.
  logic [7:0] idw_sel_r;
  // Last read answer; it holds until the next read strobe.
  logic [7:0] rdata_r;
  // Command sequencer state and its next value.
  atx_state_t state_r;
  atx_state_t state_nxt;
  // One-cycle pulse after each command write.
  logic valid_r;
  // Kind of the last command: 48-bit form, and refused for CHS mode.
  logic ext_r;
  logic bad_r;
  // Opcode of the last command.
  logic [7:0] code_r;
  // Address, count and features latched with the last command.
  logic [47:0] lba_r;
  logic [15:0] count_r;
  logic [15:0] feat_r;
  // Native maximum address, a build-time constant kept in flops.
  logic [47:0] nmax_r;

  // One bus per FIFO register: features, count, LBA low, mid, high.
  atx_bus_if fb[NFIFO] ();
  logic [7:0] f_new [NFIFO];
  logic [7:0] f_prev [NFIFO];
  logic [3:0] f_off [NFIFO];
  assign f_off[0] = ATX_OFF_FEAT;
  assign f_off[1] = ATX_OFF_SCNT;
  assign f_off[2] = ATX_OFF_LBAL;
  assign f_off[3] = ATX_OFF_LBAM;
  assign f_off[4] = ATX_OFF_LBAH;

  // Command-block writes, including the command register itself.
  // Offsets zero to seven form the command block; the rest are control or block-specific.
  wire cmdblk_wr = reg_wr && (reg_addr <= ATX_OFF_CMD);
  // A write to the command offset starts a command.
  wire cmd_wr = reg_wr && (reg_addr == ATX_OFF_CMD);
  // The select bit as software last left it.
  wire hob = devctl_r[ATX_HOB_BIT];

  // One two-entry FIFO per register; the read mux picks an entry.
  genvar gi;
  generate
    for (gi = 0; gi < NFIFO; gi++) begin : g_fifo
      // Writes ignore the select bit entirely.
      assign fb[gi].wr = reg_wr && (reg_addr == f_off[gi]);
      assign fb[gi].wdata = reg_wdata;
      assign f_new[gi] = fb[gi].newest;
      assign f_prev[gi] = fb[gi].prev;
      // Each write shifts the older byte down one place.
      atx_fifo2 u_fifo (
        .mclk(mclk),
        .rst_b(rst_b),
        .bus(fb[gi])
      );
    end
  endgenerate

  // Command decode: the byte on the write bus is the opcode.
  wire [7:0] op = reg_wdata;
  // Extended cache flush.
  wire op_flush = (op == ATX_C_FLUSH_X);
  // Extended DMA transfers, in either direction.
  wire op_dma = (op == ATX_C_RDMA_X) || (op == ATX_C_WDMA_X);
  // Extended multiple-sector transfers.
  wire op_mul = (op == ATX_C_RMUL_X) || (op == ATX_C_WMUL_X);
  // Extended single-sector transfers and the verify read.
  wire op_sec = (op == ATX_C_RSEC_X) || (op == ATX_C_WSEC_X) ||
                (op == ATX_C_RVER_X);
  // Extended native-max read and set-max.
  wire op_max = (op == ATX_C_RNMAX_X) || (op == ATX_C_SMAX_X);
  // Any of these is a 48-bit form; every other opcode is taken as 28-bit.
  wire is_ext = op_flush || op_dma || op_mul || op_sec || op_max;
  // Native-max queries report the stored limit, not the task file.
  wire op_nmax48 = (op == ATX_C_RNMAX_X);
  wire op_nmax28 = (op == ATX_C_RNMAX);
  // LBA-mode bit of the device register; 48-bit forms need it set.
  wire lba_mode = dev_r[ATX_LBA_MODE_BIT];
  // Sequencer is busy from a command write until it is idle again.
  wire busy = (state_r != ATX_IDLE);

  // Address forms; 48-bit uses previous bytes as the upper half.
  wire [47:0] lba48 = {f_prev[4], f_prev[3], f_prev[2],
                       f_new[4], f_new[3], f_new[2]};
  // The 28-bit form takes its top nibble from the device register.
  wire [47:0] lba28 = {20'h0_0000, dev_r[3:0],
                       f_new[4], f_new[3], f_new[2]};
  // Zero count in 48-bit form means 65536 sectors; left to firmware.
  wire [15:0] cnt48 = {f_prev[1], f_new[1]};
  wire [15:0] cnt28 = {8'h00, f_new[1]};
  // Native-max clamp for the 28-bit query.
  wire [47:0] nmax28 = (nmax_r > ATX_MAX28) ? ATX_MAX28 : nmax_r;

  // Identify word read mux.
  // The selected word is built here and read out one byte at a time.
  logic [15:0] idw_val;
  always_comb begin
    case (idw_sel_r)
      // Capability word: only the 48-bit flag is reported here.
      ATX_IDW_83: idw_val = 16'h0001 << ATX_ID83_48BIT;
      // Highest 48-bit LBA, least significant word first.
      ATX_IDW_100: idw_val = nmax_r[15:0];
      ATX_IDW_101: idw_val = nmax_r[31:16];
      ATX_IDW_102: idw_val = nmax_r[47:32];
      ATX_IDW_103: idw_val = 16'h0000;
      // Words this block does not model read as zero.
      default: idw_val = 16'h0000;
    endcase
  end

  // Read mux for FIFO registers by select bit.
  // Reads never move the entries, so either one may be read many times.
  // The hit flag tells the full mux that the offset is a FIFO register.
  logic [7:0] fifo_rd;
  logic fifo_hit;
  always_comb begin
    fifo_rd = 8'h00;
    fifo_hit = 1'b0;
    for (int i = 0; i < NFIFO; i++) begin
      if (reg_addr == f_off[i]) begin
        fifo_hit = 1'b1;
        fifo_rd = hob ? f_prev[i] : f_new[i];
      end
    end
  end

  // Full read mux; unmapped offsets read as zero.
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (fifo_hit) begin
      rd_mux = fifo_rd;
    end else begin
      case (reg_addr)
        // Device register reads back as written; control as written unless a command-block write cleared the select bit.
        ATX_OFF_DEV: rd_mux = dev_r;
        ATX_OFF_DEVCTL: rd_mux = devctl_r;
        // Status: busy, refused, 48-bit form and the start pulse.
        ATX_OFF_STAT: rd_mux = {4'h0, busy, bad_r, ext_r, valid_r};
        // Results of the last command, one byte per offset.
        ATX_OFF_ADDR0: rd_mux = lba_r[7:0];
        ATX_OFF_ADDR1: rd_mux = lba_r[15:8];
        ATX_OFF_ADDR2: rd_mux = lba_r[23:16];
        ATX_OFF_CNT: rd_mux = count_r[7:0];
        ATX_OFF_CNTH: rd_mux = count_r[15:8];
        // Selected identify word: low byte here, high byte at offset 0.
        ATX_OFF_IDW: rd_mux = idw_val[7:0];
        ATX_OFF_DATA: rd_mux = idw_val[15:8];
        default: rd_mux = 8'h00;
      endcase
    end
  end

  // Read data registered for next-cycle answer.
  // Holding the last answer keeps the port quiet between reads.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      rdata_r <= rd_mux;
    end
  end

  // Device control: select bit cleared by command-block writes.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      devctl_r <= ATX_DEVCTL_RST;
    end else if (reg_wr && reg_addr == ATX_OFF_DEVCTL) begin
      // Device control is not in the command block; it sets the bit.
      devctl_r <= reg_wdata;
    end else if (cmdblk_wr) begin
      // Any command-block write drops the select bit.
      devctl_r[ATX_HOB_BIT] <= 1'b0;
    end
  end

  // Device register and identify word select.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dev_r <= 8'h00;
      idw_sel_r <= 8'h00;
      nmax_r <= NATIVE_MAX;
    end else begin
      // The limit never changes; the flop only keeps outputs flop-fed.
      nmax_r <= NATIVE_MAX;
      // Device register: LBA-mode bit and the 28-bit top nibble.
      if (reg_wr && reg_addr == ATX_OFF_DEV) begin
        dev_r <= reg_wdata;
      end
      // Identify word select; the word is read back a byte at a time.
      if (reg_wr && reg_addr == ATX_OFF_IDW) begin
        idw_sel_r <= reg_wdata;
      end
    end
  end

  // Command sequencer: latch then report completion.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      // Wait for a write to the command offset.
      ATX_IDLE: if (cmd_wr) state_nxt = ATX_LATCH;
      // Results were latched on the way in; report for one more cycle.
      ATX_LATCH: state_nxt = ATX_DONE;
      // A back-to-back command is taken at once.
      ATX_DONE: state_nxt = cmd_wr ? ATX_LATCH : ATX_IDLE;
      default: state_nxt = ATX_IDLE;
    endcase
  end

  // Each command latches its own address form, so mixing is safe.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ATX_IDLE;
      valid_r <= 1'b0;
      ext_r <= 1'b0;
      bad_r <= 1'b0;
      code_r <= 8'h00;
      lba_r <= 48'h0000_0000_0000;
      count_r <= 16'h0000;
      feat_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      // The start pulse is one cycle wide, whatever the opcode.
      valid_r <= cmd_wr;
      if (cmd_wr) begin
        code_r <= op;
        ext_r <= is_ext;
        // A 48-bit form without LBA mode is flagged, not executed.
        bad_r <= is_ext && !lba_mode;
        if (op_nmax48) begin
          lba_r <= nmax_r;
        end else if (op_nmax28) begin
          lba_r <= nmax28;
        end else begin
          // Native-max queries aside, the opcode picks 28- or 48-bit.
          lba_r <= is_ext ? lba48 : lba28;
        end
        // Count and features use both entries only for 48-bit forms.
        count_r <= is_ext ? cnt48 : cnt28;
        feat_r <= is_ext ? {f_prev[0], f_new[0]} : {8'h00, f_new[0]};
      end
    end
  end

  // Outputs straight from flops.
  // Register read port.
  assign reg_rdata = rdata_r;
  // Command results, all but the cmd_valid pulse held until the next command.
  assign cmd_valid = valid_r;
  assign cmd_ext = ext_r;
  assign cmd_bad = bad_r;
  assign cmd_code = code_r;
  assign cmd_lba = lba_r;
  assign cmd_count = count_r;
  assign cmd_feat = feat_r;
endmodule

/* sim/atx_taskfile_assertions.sv */
// Checker for the task-file block, bound to the top module's ports.
// Assumes one clock domain and reads answered one cycle after strobe.
`timescale 1ns/10ps
module atx_taskfile_chk
  import atx_pkg::*;
#(
  parameter logic [47:0] NATIVE_MAX = ATX_NATIVE_MAX_DEF
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Command outputs.
  input wire logic cmd_valid,
  input wire logic cmd_ext,
  input wire logic cmd_bad,
  input wire logic [7:0] cmd_code,
  input wire logic [47:0] cmd_lba,
  input wire logic [15:0] cmd_count,
  input wire logic [15:0] cmd_feat
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Write decodes shared by the properties.
  wire logic cmd_wr = reg_wr && (reg_addr == ATX_OFF_CMD);
  wire logic feat_wr = reg_wr && (reg_addr == ATX_OFF_FEAT);
  // Shadow of the features pair, select bit and LBA-mode bit.
  logic [7:0] fnew_r, fold_r;
  logic hob_r, lba_r;
  // Only features is shadowed; the other four share its logic.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fnew_r <= ATX_BYTE_RST;
      fold_r <= ATX_BYTE_RST;
      hob_r <= 1'b0;
      lba_r <= 1'b0;
    end else if (reg_wr) begin
      if (feat_wr) begin
        fnew_r <= reg_wdata;
        fold_r <= fnew_r;
      end
      if (reg_addr == ATX_OFF_DEV) begin
        lba_r <= reg_wdata[ATX_LBA_MODE_BIT];
      end
      if (reg_addr == ATX_OFF_DEVCTL) begin
        hob_r <= reg_wdata[ATX_HOB_BIT];
      end else if (reg_addr <= ATX_OFF_CMD) begin
        hob_r <= 1'b0;
      end
    end
  end
  cmd_start_a: assert property (
    cmd_wr |=> cmd_valid && cmd_code == $past(reg_wdata))
    else $error("command write gave no pulse");
  pulse_cause_a: assert property (cmd_valid |-> $past(cmd_wr))
    else $error("command pulse without a command write");
  clamp_28_a: assert property (
    cmd_wr && reg_wdata == ATX_C_RNMAX |=> !cmd_ext &&
    cmd_lba == ((NATIVE_MAX > ATX_MAX28) ? ATX_MAX28 : NATIVE_MAX))
    else $error("short native max not clamped");
  full_max_a: assert property (
    cmd_wr && reg_wdata == ATX_C_RNMAX_X |=> cmd_ext && cmd_lba == NATIVE_MAX)
    else $error("long native max wrong");
  lba_only_a: assert property (
    cmd_wr && reg_wdata == ATX_C_RSEC_X |=> cmd_bad == !$past(lba_r))
    else $error("bad flag wrong for long command");
  hob_read_a: assert property (
    reg_rd && reg_addr == ATX_OFF_FEAT |=>
    reg_rdata == ($past(hob_r) ? $past(fold_r) : $past(fnew_r)))
    else $error("features read returned wrong entry");
  feat_pair_a: assert property (
    cmd_wr && reg_wdata == ATX_C_RDMA_X |=>
    cmd_feat == {$past(fold_r), $past(fnew_r)})
    else $error("features pair wrong");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  cover property (cmd_wr && reg_wdata == ATX_C_RNMAX);
  cover property (reg_rd && reg_addr == ATX_OFF_FEAT && hob_r);
  cover property (cmd_wr ##1 cmd_bad);
endmodule
bind atx_taskfile atx_taskfile_chk #(.NATIVE_MAX(NATIVE_MAX)) u_atx_chk (
  .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .cmd_valid(cmd_valid), .cmd_ext(cmd_ext), .cmd_bad(cmd_bad),
  .cmd_code(cmd_code), .cmd_lba(cmd_lba), .cmd_count(cmd_count),
  .cmd_feat(cmd_feat));

/* sim/atx_host_model.sv */
// Host model driving the task-file register port.
// Assumes read data stand in the cycle after the read strobe.
`timescale 1ns/10ps
module atx_host_model (
  // Clock.
  input wire logic mclk,
  // Register port toward the device.
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  // Idle bus at time zero.
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One write cycle; data inverted after so stale bytes are not reused.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
    #1;
  endtask
  // One read cycle; data taken once the answering edge has settled.
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule

/* sim/tb_atx_taskfile.sv */
// Testbench for the task-file block with a host model on its port.
// Assumes the checker is bound to the top module.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  err_total++; $display("wrong value %s expected %h seen %h", nm, e, g); \
  end end
module tb_atx_taskfile;
  import atx_pkg::*;
  // Above the short limit so the clamp is exercised.
  localparam logic [47:0] NMAX = 48'h0001_2345_6789;
  logic mclk, rst_b, reg_wr, reg_rd, cmd_valid, cmd_ext, cmd_bad;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, cmd_code, rv;
  logic [47:0] cmd_lba;
  logic [15:0] cmd_count, cmd_feat;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [7:0] ops [10] = '{ATX_C_FLUSH_X, ATX_C_RDMA_X, ATX_C_RMUL_X,
    ATX_C_RNMAX_X, ATX_C_RSEC_X, ATX_C_RVER_X, ATX_C_SMAX_X, ATX_C_WDMA_X,
    ATX_C_WMUL_X, ATX_C_WSEC_X};
  atx_taskfile #(.NATIVE_MAX(NMAX)) u_atx_taskfile (.mclk(mclk),
    .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmd_valid(cmd_valid), .cmd_ext(cmd_ext), .cmd_bad(cmd_bad),
    .cmd_code(cmd_code), .cmd_lba(cmd_lba), .cmd_count(cmd_count),
    .cmd_feat(cmd_feat));
  atx_host_model u_atx_host_model (.mclk(mclk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  // Read one register and compare it.
  task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
    u_atx_host_model.rd(a, rv);
    `CHK("read data", e, rv)
  endtask
  // Print counts and the verdict, then stop.
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // A hang is cut short well past the expected run length.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    rst_b = 1'b0;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    for (int i = 1; i <= 5; i++) begin
      u_atx_host_model.wr(4'(i), 8'h10 + 8'(i));
      u_atx_host_model.wr(4'(i), 8'hA0 + 8'(i));
    end
    for (int i = 1; i <= 5; i++) chk_rd(4'(i), 8'hA0 + 8'(i));
    u_atx_host_model.wr(ATX_OFF_DEVCTL, 8'h80);
    for (int i = 1; i <= 5; i++) chk_rd(4'(i), 8'h10 + 8'(i));
    u_atx_host_model.wr(ATX_OFF_DEV, 8'h40);
    chk_rd(ATX_OFF_FEAT, 8'hA1);
    u_atx_host_model.wr(ATX_OFF_CMD, ATX_C_RDMA_X);
    `CHK("lba", {48'h1514_13A5_A4A3}, cmd_lba)
    `CHK("count", 16'h12A2, cmd_count)
    `CHK("flags", 3'b110, {cmd_valid, cmd_ext, cmd_bad})
    `CHK("feat", 16'h11A1, cmd_feat)
    u_atx_host_model.wr(ATX_OFF_CMD, ATX_C_RNMAX);
    `CHK("short max", ATX_MAX28, cmd_lba)
    `CHK("short ext", 1'b0, cmd_ext)
    u_atx_host_model.wr(ATX_OFF_CMD, ATX_C_RNMAX_X);
    `CHK("long max", NMAX, cmd_lba)
    chk_rd(ATX_OFF_STAT, 8'h0A);
    u_atx_host_model.wr(ATX_OFF_DEVCTL, 8'h80);
    u_atx_host_model.wr(ATX_OFF_FEAT, 8'h5A);
    chk_rd(ATX_OFF_FEAT, 8'h5A);
    u_atx_host_model.wr(ATX_OFF_DEVCTL, 8'h80);
    chk_rd(ATX_OFF_FEAT, 8'hA1);
    foreach (ops[k]) begin
      u_atx_host_model.wr(ATX_OFF_CMD, ops[k]);
      `CHK("opcode", ops[k], cmd_code)
      `CHK("ext", 1'b1, cmd_ext)
    end
    u_atx_host_model.wr(ATX_OFF_DEV, 8'h00);
    u_atx_host_model.wr(ATX_OFF_CMD, ATX_C_RSEC_X);
    `CHK("bad", 1'b1, cmd_bad)
    u_atx_host_model.wr(ATX_OFF_IDW, ATX_IDW_83);
    chk_rd(ATX_OFF_IDW, 8'h00);
    chk_rd(ATX_OFF_DATA, 8'((16'h0001 << ATX_ID83_48BIT) >> 8));
    for (int w = 100; w <= 103; w++) begin
      u_atx_host_model.wr(ATX_OFF_IDW, 8'(w));
      chk_rd(ATX_OFF_IDW, 8'(NMAX >> (16 * (w - 100))));
      chk_rd(ATX_OFF_DATA, 8'(NMAX >> (16 * (w - 100) + 8)));
    end
    summarize();
  end
endmodule
